/* File: dscu_pkg.sv */
// constants and types for the disk security command unit
package dscu_pkg;
    localparam logic [7:0] CMD_DISABLE_PW = 8'hf6;
    localparam logic [7:0] CMD_ERASE_PREP = 8'hf3;
    localparam logic [7:0] CMD_ERASE_UNIT = 8'hf4;
    localparam logic [3:0] CMD_RECAL_HI = 4'h1;
    localparam int DH_FIXED_HI_BIT = 7;
    localparam int DH_FIXED_LO_BIT = 5;
    localparam int STAT_BSY_BIT = 7;
    localparam int STAT_RDY_BIT = 6;
    localparam int STAT_DSC_BIT = 4;
    localparam int STAT_DRQ_BIT = 3;
    localparam int STAT_ERR_BIT = 0;
    localparam int ERR_ABT_BIT = 2;
    localparam int ERR_TON_BIT = 1;
    localparam int CTL_SEL_BIT = 0;
    localparam int CTL_MODE_BIT = 1;
    localparam int WORD_BITS = 16;
    localparam int PW_FIRST_WORD = 1;
    localparam int PW_LAST_WORD = 16;
    localparam int PW_BITS = 256;
    localparam logic [7:0] SECTOR_LAST_WORD = 8'hff;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam int LBA_BITS = 48;
    localparam int IDENT_WORD_ERASE_TIME = 89;
    localparam logic [15:0] ERASE_TIME_DEFAULT = 16'h0001;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] dev_head;
    } dscu_cmd_s;

    typedef enum logic [4:0] {
        DSCU_IDLE = 5'h01,
        DSCU_XFER = 5'h02,
        DSCU_CHECK = 5'h04,
        DSCU_ERASE = 5'h08,
        DSCU_RECAL = 5'h10
    } dscu_state_e;
endpackage : dscu_pkg

/* File: dscu_top.sv */
// disk security command unit: disable password, erase prepare, erase unit, recalibrate
`timescale 1ns/1ps
module dscu_top #(
    parameter logic [15:0] ERASE_TIME = dscu_pkg::ERASE_TIME_DEFAULT
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic cmd_we_i,
    input wire dscu_pkg::dscu_cmd_s cmd_i,
    input wire logic data_valid_i,
    input wire logic [dscu_pkg::WORD_BITS-1:0] data_i,
    output logic data_ready_o,
    input wire logic [dscu_pkg::PW_BITS-1:0] user_pw_i,
    input wire logic [dscu_pkg::PW_BITS-1:0] master_pw_i,
    input wire logic lock_set_i,
    output logic lock_en_o,
    input wire logic [dscu_pkg::LBA_BITS-1:0] native_max_lba_i,
    output logic erase_req_o,
    output logic [dscu_pkg::LBA_BITS-1:0] erase_lba_o,
    input wire logic erase_ack_i,
    output logic recal_req_o,
    input wire logic recal_done_i,
    input wire logic recal_track0_i,
    output logic [7:0] command_error_flags_o,
    output logic [7:0] command_status_flags_o,
    output logic cmd_done_o,
    output logic [15:0] ident_erase_time_o
);
    dscu_pkg::dscu_state_e state_q;
    logic op_erase_q;
    logic [7:0] word_cnt_q;
    logic [dscu_pkg::WORD_BITS-1:0] ctrl_q;
    logic [dscu_pkg::PW_BITS-1:0] pw_q;
    logic [dscu_pkg::LBA_BITS-1:0] lba_q;
    logic lock_en_q;
    logic prep_armed_q;
    logic [7:0] err_q;
    logic err_flag_q;
    logic done_q;
    logic cmd_take;
    logic dh_ok;
    logic is_recal;
    logic pw_match;
    logic abort_now;
    logic ok_now;
    logic ton_now;
    logic unlock_now;
    logic start_erase;
    logic erase_last;

    assign cmd_take = cmd_we_i && (state_q == dscu_pkg::DSCU_IDLE);
    // both fixed device/head bits must be one for the command to count
    assign dh_ok = cmd_i.dev_head[dscu_pkg::DH_FIXED_HI_BIT]
        && cmd_i.dev_head[dscu_pkg::DH_FIXED_LO_BIT];
    assign is_recal = (cmd_i.code[7:4] == dscu_pkg::CMD_RECAL_HI);
    // full 32 bytes always significant
    assign pw_match = ctrl_q[dscu_pkg::CTL_SEL_BIT] ? (pw_q == master_pw_i)
        : (pw_q == user_pw_i);
    assign erase_last = (lba_q == native_max_lba_i);

    // one decision per cycle; only one of the idle or check arms can fire
    always_comb begin
        abort_now = 1'b0;
        ok_now = 1'b0;
        ton_now = 1'b0;
        unlock_now = 1'b0;
        start_erase = 1'b0;
        if (cmd_take) begin
            if (!dh_ok) begin
                abort_now = 1'b1;
            end else if (cmd_i.code == dscu_pkg::CMD_ERASE_PREP) begin
                ok_now = 1'b1;
            end else if (cmd_i.code == dscu_pkg::CMD_ERASE_UNIT) begin
                abort_now = !prep_armed_q;
            end else if (cmd_i.code != dscu_pkg::CMD_DISABLE_PW && !is_recal) begin
                abort_now = 1'b1;
            end
        end
        if (state_q == dscu_pkg::DSCU_CHECK) begin
            if (!lock_en_q && !ctrl_q[dscu_pkg::CTL_SEL_BIT]) begin
                abort_now = 1'b1;
            end else if (op_erase_q && ctrl_q[dscu_pkg::CTL_MODE_BIT]) begin
                abort_now = 1'b1;
            end else if (op_erase_q) begin
                // lock off: no comparison at all
                start_erase = !lock_en_q || pw_match;
                abort_now = lock_en_q && !pw_match;
            end else begin
                unlock_now = pw_match;
                ok_now = pw_match;
                abort_now = !pw_match;
            end
        end
        if (state_q == dscu_pkg::DSCU_ERASE && erase_ack_i && erase_last) begin
            unlock_now = 1'b1;
            ok_now = 1'b1;
        end
        if (state_q == dscu_pkg::DSCU_RECAL && recal_done_i) begin
            ton_now = !recal_track0_i;
            ok_now = recal_track0_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= dscu_pkg::DSCU_IDLE;
            op_erase_q <= 1'b0;
        end else begin
            unique case (state_q)
                dscu_pkg::DSCU_IDLE: begin
                    if (cmd_take && !abort_now && !ok_now) begin
                        op_erase_q <= (cmd_i.code == dscu_pkg::CMD_ERASE_UNIT);
                        state_q <= is_recal ? dscu_pkg::DSCU_RECAL : dscu_pkg::DSCU_XFER;
                    end
                end
                dscu_pkg::DSCU_XFER: begin
                    if (data_valid_i && word_cnt_q == dscu_pkg::SECTOR_LAST_WORD) begin
                        state_q <= dscu_pkg::DSCU_CHECK;
                    end
                end
                dscu_pkg::DSCU_CHECK: begin
                    state_q <= start_erase ? dscu_pkg::DSCU_ERASE : dscu_pkg::DSCU_IDLE;
                end
                dscu_pkg::DSCU_ERASE: begin
                    if (erase_ack_i && erase_last) begin
                        state_q <= dscu_pkg::DSCU_IDLE;
                    end
                end
                dscu_pkg::DSCU_RECAL: begin
                    if (recal_done_i) begin
                        state_q <= dscu_pkg::DSCU_IDLE;
                    end
                end
                default: begin
                    state_q <= dscu_pkg::DSCU_IDLE;
                end
            endcase
        end
    end

    // parameter sector capture; reserved words are read and dropped
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            word_cnt_q <= 8'h00;
            ctrl_q <= 16'h0000;
            pw_q <= '0;
        end else if (cmd_take) begin
            word_cnt_q <= 8'h00;
        end else if (state_q == dscu_pkg::DSCU_XFER && data_valid_i) begin
            word_cnt_q <= word_cnt_q + 8'h01;
            if (word_cnt_q == 8'h00) begin
                ctrl_q <= data_i;
            end
            for (int i = dscu_pkg::PW_FIRST_WORD; i <= dscu_pkg::PW_LAST_WORD; i++) begin
                if (word_cnt_q == 8'(i)) begin
                    pw_q[(i-dscu_pkg::PW_FIRST_WORD)*dscu_pkg::WORD_BITS +: 16] <= data_i;
                end
            end
        end
    end

    // erase walks every block; only zero sectors are written, nothing is read back
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            lba_q <= '0;
        end else if (start_erase) begin
            lba_q <= '0;
        end else if (state_q == dscu_pkg::DSCU_ERASE && erase_ack_i && !erase_last) begin
            lba_q <= lba_q + 48'h000000000001;
        end
    end

    // lock state only; the stored passwords live outside and are never written here
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            lock_en_q <= 1'b0;
        end else if (lock_set_i) begin
            lock_en_q <= 1'b1;
        end else if (unlock_now) begin
            lock_en_q <= 1'b0;
        end
    end

    // any accepted command other than a good prepare disarms the erase
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            prep_armed_q <= 1'b0;
        end else if (cmd_take) begin
            prep_armed_q <= dh_ok && (cmd_i.code == dscu_pkg::CMD_ERASE_PREP);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            err_q <= dscu_pkg::ERR_RESET;
            err_flag_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= abort_now || ok_now || ton_now;
            if (abort_now) begin
                err_q <= 8'h00 | (8'h01 << dscu_pkg::ERR_ABT_BIT);
                err_flag_q <= 1'b1;
            end else if (ton_now) begin
                err_q <= 8'h00 | (8'h01 << dscu_pkg::ERR_TON_BIT);
                err_flag_q <= 1'b1;
            end else if (cmd_take) begin
                err_q <= dscu_pkg::ERR_RESET;
                err_flag_q <= 1'b0;
            end
        end
    end

    always_comb begin
        command_status_flags_o = 8'h00;
        command_status_flags_o[dscu_pkg::STAT_BSY_BIT] = (state_q != dscu_pkg::DSCU_IDLE)
            && (state_q != dscu_pkg::DSCU_XFER);
        command_status_flags_o[dscu_pkg::STAT_RDY_BIT] = 1'b1;
        command_status_flags_o[dscu_pkg::STAT_DSC_BIT] = 1'b1;
        command_status_flags_o[dscu_pkg::STAT_DRQ_BIT] = (state_q == dscu_pkg::DSCU_XFER);
        command_status_flags_o[dscu_pkg::STAT_ERR_BIT] = err_flag_q;
    end

    assign command_error_flags_o = err_q;
    assign data_ready_o = (state_q == dscu_pkg::DSCU_XFER);
    assign erase_req_o = (state_q == dscu_pkg::DSCU_ERASE);
    assign erase_lba_o = lba_q;
    assign recal_req_o = (state_q == dscu_pkg::DSCU_RECAL);
    assign lock_en_o = lock_en_q;
    assign cmd_done_o = done_q;
    assign ident_erase_time_o = ERASE_TIME;

    property p_bad_devhead;
        @(posedge sys_clk_i) disable iff (srst_i)
        cmd_take && !dh_ok |=> err_q[dscu_pkg::ERR_ABT_BIT] && state_q == dscu_pkg::DSCU_IDLE;
    endproperty
    a_bad_devhead: assert property (p_bad_devhead) else $error("bad device/head not aborted");

    property p_prep_no_data;
        @(posedge sys_clk_i) disable iff (srst_i)
        cmd_take && dh_ok && cmd_i.code == dscu_pkg::CMD_ERASE_PREP
        |=> !data_ready_o && cmd_done_o && !err_flag_q && prep_armed_q;
    endproperty
    a_prep_no_data: assert property (p_prep_no_data) else $error("prepare asked for data");

    property p_disable_xfer;
        @(posedge sys_clk_i) disable iff (srst_i)
        cmd_take && dh_ok && cmd_i.code == dscu_pkg::CMD_DISABLE_PW |=> data_ready_o;
    endproperty
    a_disable_xfer: assert property (p_disable_xfer) else $error("no sector request");

    property p_no_prep;
        @(posedge sys_clk_i) disable iff (srst_i)
        cmd_take && dh_ok && cmd_i.code == dscu_pkg::CMD_ERASE_UNIT && !prep_armed_q
        |=> err_q[dscu_pkg::ERR_ABT_BIT] && !data_ready_o;
    endproperty
    a_no_prep: assert property (p_no_prep) else $error("erase without prepare ran");

    property p_sector_len;
        @(posedge sys_clk_i) disable iff (srst_i)
        state_q == dscu_pkg::DSCU_XFER && data_valid_i && word_cnt_q == 8'hff
        |=> state_q == dscu_pkg::DSCU_CHECK;
    endproperty
    a_sector_len: assert property (p_sector_len) else $error("sector length wrong");

    property p_user_when_off;
        @(posedge sys_clk_i) disable iff (srst_i)
        state_q == dscu_pkg::DSCU_CHECK && !lock_en_q && !ctrl_q[0]
        |=> err_q[dscu_pkg::ERR_ABT_BIT] && state_q == dscu_pkg::DSCU_IDLE;
    endproperty
    a_user_when_off: assert property (p_user_when_off) else $error("user select not aborted");

    property p_mismatch;
        @(posedge sys_clk_i) disable iff (srst_i)
        state_q == dscu_pkg::DSCU_CHECK && op_erase_q && lock_en_q && !pw_match
        |=> err_flag_q && !erase_req_o;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not rejected");

    property p_erase_no_cmp;
        @(posedge sys_clk_i) disable iff (srst_i)
        state_q == dscu_pkg::DSCU_CHECK && op_erase_q && !lock_en_q && ctrl_q[1:0] == 2'b01
        |=> erase_req_o && erase_lba_o == 48'h000000000000;
    endproperty
    a_erase_no_cmp: assert property (p_erase_no_cmp) else $error("erase with lock off refused");

    property p_erase_end;
        @(posedge sys_clk_i) disable iff (srst_i)
        erase_req_o && erase_ack_i && erase_last && !lock_set_i
        |=> !lock_en_o && !erase_req_o && cmd_done_o;
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase end did not unlock");

    property p_abort_flags;
        @(posedge sys_clk_i) disable iff (srst_i)
        abort_now |=> command_status_flags_o[0] && !command_status_flags_o[7] && err_q[2];
    endproperty
    a_abort_flags: assert property (p_abort_flags) else $error("abort flags wrong");

    property p_recal_ton;
        @(posedge sys_clk_i) disable iff (srst_i)
        recal_req_o && recal_done_i && !recal_track0_i |=> err_q[dscu_pkg::ERR_TON_BIT];
    endproperty
    a_recal_ton: assert property (p_recal_ton) else $error("track zero flag missing");

    c_disable_ok: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        state_q == dscu_pkg::DSCU_CHECK && !op_erase_q && pw_match ##1 !lock_en_o);
    c_erase_run: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        erase_req_o && erase_ack_i && erase_last);
    c_prep_then_erase: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        prep_armed_q && cmd_take && cmd_i.code == dscu_pkg::CMD_ERASE_UNIT);
endmodule : dscu_top

/* File: dscu_host_model.sv */
// host controller model: command register writes and parameter sectors
`timescale 1ns/1ps
module dscu_host_model (
    input wire logic sys_clk_i,
    input wire logic data_ready_i,
    output logic cmd_we_o,
    output dscu_pkg::dscu_cmd_s cmd_o,
    output logic data_valid_o,
    output logic [15:0] data_o
);
    initial begin
        cmd_we_o = 1'b0;
        cmd_o = '0;
        data_valid_o = 1'b0;
        data_o = 16'h0000;
    end

    // one-cycle strobe; fields inverted after release so stale values never match
    task automatic write_cmd(input logic [7:0] code,
                             input logic [7:0] dh);
        @(posedge sys_clk_i);
        #1;
        cmd_we_o = 1'b1;
        cmd_o = '{code: code, dev_head: dh};
        @(posedge sys_clk_i);
        #1;
        cmd_we_o = 1'b0;
        cmd_o = ~cmd_o;
    endtask : write_cmd

    // word 0 control, words 1-16 password, rest reserved filler
    task automatic send_sector(input logic [15:0] ctl, input logic [255:0] pw,
                               input int stall);
        int n;
        for (int i = 0; i < 256; i++) begin
            if (stall > 0 && i % 64 == 1) begin
                data_valid_o = 1'b0;
                data_o = ~data_o;
                repeat (stall) @(posedge sys_clk_i);
                #1;
            end
            n = 0;
            while (data_ready_i !== 1'b1 && n < 50) begin
                @(posedge sys_clk_i);
                #1;
                n++;
            end
            data_valid_o = 1'b1;
            data_o = (i == 0) ? ctl : (i <= 16) ? pw[(i-1)*16 +: 16] : 16'hffff - 16'(i);
            @(posedge sys_clk_i);
            #1;
        end
        data_valid_o = 1'b0;
        data_o = ~data_o;
    endtask : send_sector
endmodule : dscu_host_model

/* File: dscu_top_tb.sv */
// self-checking testbench for the disk security command unit
`timescale 1ns/1ps
module dscu_top_tb;
    localparam logic [7:0] DH = 8'he0;
    localparam logic [255:0] USER = {8{32'h1234_5678}};
    localparam logic [255:0] MASTER = {8{32'h9abc_def0}};
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cmd_we_i, data_valid_i, data_ready_o, lock_set_i = 1'b0, lock_en_o;
    dscu_pkg::dscu_cmd_s cmd_i;
    logic [15:0] data_i, ident_erase_time_o;
    logic [47:0] erase_lba_o;
    logic erase_req_o, erase_ack_i = 1'b0, recal_req_o, recal_done_i = 1'b0, recal_track0_i = 1'b0;
    logic [7:0] command_error_flags_o, command_status_flags_o;
    logic cmd_done_o, drq_seen, slow = 1'b0;
    int fails = 0, checked = 0, acks = 0, rc = 0, cycles = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    dscu_host_model host_u (.sys_clk_i(sys_clk_i), .data_ready_i(data_ready_o),
        .cmd_we_o(cmd_we_i), .cmd_o(cmd_i), .data_valid_o(data_valid_i), .data_o(data_i));

    dscu_top #(.ERASE_TIME(16'h0007)) dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .cmd_we_i(cmd_we_i), .cmd_i(cmd_i), .data_valid_i(data_valid_i), .data_i(data_i),
        .data_ready_o(data_ready_o), .user_pw_i(USER), .master_pw_i(MASTER),
        .lock_set_i(lock_set_i), .lock_en_o(lock_en_o), .native_max_lba_i(48'h5),
        .erase_req_o(erase_req_o), .erase_lba_o(erase_lba_o), .erase_ack_i(erase_ack_i),
        .recal_req_o(recal_req_o), .recal_done_i(recal_done_i),
        .recal_track0_i(recal_track0_i), .command_error_flags_o(command_error_flags_o),
        .command_status_flags_o(command_status_flags_o), .cmd_done_o(cmd_done_o),
        .ident_erase_time_o(ident_erase_time_o));

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (exp !== got) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic summarize;
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // media side: acks sectors (every third cycle when slow), ends recalibrate after 3 cycles
    always begin
        @(posedge sys_clk_i);
        #1;
        cycles++;
        if (data_ready_o === 1'b1) drq_seen = 1'b1;
        if (erase_req_o === 1'b1 && (!slow || cycles % 3 == 0)) check("erase lba", acks, erase_lba_o);
        erase_ack_i = (erase_req_o === 1'b1 && (!slow || cycles % 3 == 0));
        if (erase_ack_i) acks++;
        recal_done_i = (recal_req_o === 1'b1 && rc == 2);
        rc = (recal_req_o === 1'b1 && rc < 2) ? rc + 1 : 0;
        if (cycles == 12000) begin
            fails++;
            summarize();
        end
    end

    task automatic lock_on;
        lock_set_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        lock_set_i = 1'b0;
        check("lock after set", 1, lock_en_o);
    endtask : lock_on

    // one command end to end: strobe, optional sector, wait done, then the register picture
    task automatic run(input logic [7:0] code, input logic [7:0] dh, input logic sec,
                       input logic [15:0] ctl, input logic [255:0] pw, input logic [7:0] exp_err,
                       input logic exp_lock, input int exp_acks);
        int n;
        acks = 0;
        drq_seen = 1'b0;
        host_u.write_cmd(code, dh);
        if (sec) host_u.send_sector(ctl, pw, slow ? 2 : 0);
        n = 0;
        while (cmd_done_o !== 1'b1 && n < 300) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check("done", 1, cmd_done_o);
        @(posedge sys_clk_i);
        #1;
        check("error reg", exp_err, command_error_flags_o);
        check("status reg", (exp_err == 8'h00) ? 8'h50 : 8'h51, command_status_flags_o);
        check("lock", exp_lock, lock_en_o);
        check("erased sectors", exp_acks, acks);
        check("data phase", sec, drq_seen);
    endtask : run

    initial begin
        repeat (3) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        check("status reset", 8'h50, command_status_flags_o);
        check("error reset", 8'h00, command_error_flags_o);
        check("lock reset", 0, lock_en_o);
        check("erase time", 16'h0007, ident_erase_time_o);
        run(8'hf6, DH, 1, 16'h0000, USER, 8'h04, 0, 0);
        lock_on();
        run(8'hf6, DH, 1, 16'h0000, USER ^ 256'h1, 8'h04, 1, 0);
        run(8'hf6, DH, 1, 16'h0001, MASTER, 8'h00, 0, 0);
        lock_on();
        run(8'hf6, DH, 1, 16'hfffc, USER, 8'h00, 0, 0);
        run(8'hf4, DH, 0, 16'h0000, USER, 8'h04, 0, 0);
        run(8'hf3, 8'hc0, 0, 16'h0000, USER, 8'h04, 0, 0);
        run(8'hf3, 8'h60, 0, 16'h0000, USER, 8'h04, 0, 0);
        lock_on();
        run(8'hf3, DH, 0, 16'h0000, USER, 8'h00, 1, 0);
        run(8'hf4, DH, 1, 16'h0000, USER ^ {1'b1, 255'h0}, 8'h04, 1, 0);
        run(8'hf3, DH, 0, 16'h0000, USER, 8'h00, 1, 0);
        run(8'hf4, DH, 1, 16'h0002, USER, 8'h04, 1, 0);
        run(8'hf3, DH, 0, 16'h0000, USER, 8'h00, 1, 0);
        slow = 1'b1;
        run(8'hf4, DH, 1, 16'h0000, USER, 8'h00, 0, 6);
        slow = 1'b0;
        run(8'hf3, DH, 0, 16'h0000, USER, 8'h00, 0, 0);
        run(8'hf4, DH, 1, 16'h0001, ~MASTER, 8'h00, 0, 6);
        run(8'hf3, DH, 0, 16'h0000, USER, 8'h00, 0, 0);
        run(8'hf4, DH, 1, 16'h0000, USER, 8'h04, 0, 0);
        run(8'hf3, DH, 0, 16'h0000, USER, 8'h00, 0, 0);
        run(8'hf6, DH, 1, 16'h0001, MASTER, 8'h00, 0, 0);
        run(8'hf4, DH, 0, 16'h0000, USER, 8'h04, 0, 0);
        run(8'h10, DH, 0, 16'h0000, USER, 8'h02, 0, 0);
        recal_track0_i = 1'b1;
        run(8'h17, DH, 0, 16'h0000, USER, 8'h00, 0, 0);
        run(8'h20, DH, 0, 16'h0000, USER, 8'h04, 0, 0);
        summarize();
    end
endmodule : dscu_top_tb
